// >>> scsb_pkg.sv
// Package of constants and types for the management/stop-clock sideband block
package scsb_pkg;
    // Synchroniser depth for asynchronous sideband pins
    localparam int SYNC_STAGES = 3;
    // Reset values
    localparam logic RST_PIN_SYNC = 1'h1;
    localparam logic RST_LOW = 1'h0;
    localparam logic RST_HIGH = 1'h1;
    // Controller states, one-hot
    typedef enum logic [6:0] {
        SCSB_RUN = 7'h01,
        SCSB_SAVE = 7'h02,
        SCSB_MGMT_ACK = 7'h04,
        SCSB_MGMT_RUN = 7'h08,
        SCSB_GRANT_ACK = 7'h10,
        SCSB_GRANT = 7'h20,
        SCSB_RESUME = 7'h40
    } scsb_state_t;
endpackage : scsb_pkg

// >>> scsb_sideband.sv
// Sideband controller for the management interrupt and halt-clock requests
// Functional notes
// - Save execution state before entering management mode
// - Issue acknowledge transaction, then run handler
// - Management request at reset release tri-states all outputs
// - Halt-clock request enters low-power grant state
// - Issue grant-acknowledge transaction on entering grant
// - Gate core clocks except bus and interrupt units
// - Keep snooping and interrupt unit clocked in grant; management request waits for resume
// - On withdrawal re-enable clocks and resume execution
// - Halt-clock request asynchronous; bus clock untouched
module scsb_sideband #(
    // Depth of each pin synchroniser
    parameter int SYNC_STAGES = scsb_pkg::SYNC_STAGES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Asynchronous sideband requests
    input wire logic mgmt_interrupt_req_n,
    input wire logic halt_clock_req_n,
    // Core handshakes
    input wire logic state_saved,
    input wire logic bus_ack_done,
    input wire logic handler_exit,
    // Bus transaction requests
    output logic save_state_req,
    output logic mgmt_ack_req,
    output logic grant_ack_req,
    // Core mode and clock control
    output logic management_mode,
    output logic handler_start,
    output logic core_clk_en,
    output logic system_bus_clk_en,
    output logic local_interrupt_controller_clk_en,
    output logic snoop_en,
    output logic resume_exec,
    // Output tri-state control
    output logic outputs_tristate
);
    // Requests are levels: a pin still low when a sequence ends starts it again,
    // so system logic withdraws it within a few cycles of acceptance.
    // Bus side, interrupt unit and snoop enables drop only during reset.
    // Outputs tristate only if a management request is settled when reset lifts.

    // Refuse synchronisers too short for the agreement test
    if (SYNC_STAGES < 3) begin : g_bad_sync_depth
        $error("synchroniser needs at least three stages");
    end

    // Whole module state as one register
    typedef struct packed {
        logic [SYNC_STAGES-1:0] mgmt_sync;
        logic [SYNC_STAGES-1:0] halt_sync;
        logic mgmt_act;
        logic halt_act;
        logic in_reset;
        scsb_pkg::scsb_state_t state;
        logic save_state_req;
        logic mgmt_ack_req;
        logic grant_ack_req;
        logic management_mode;
        logic handler_start;
        logic core_clk_en;
        logic resume_exec;
        logic outputs_tristate;
        logic bus_clk_en;
        logic irq_unit_clk_en;
        logic snoop_en;
    } scsb_regs_t;

    // Registered state and its next value
    scsb_regs_t q;
    scsb_regs_t d;

    // Shift a pin sample into a synchroniser chain
    function automatic logic [SYNC_STAGES-1:0] shift_in(input logic [SYNC_STAGES-1:0] chain, input logic pin);
        return {chain[SYNC_STAGES-2:0], pin};
    endfunction : shift_in

    // Active level once the last two stages agree, else the held one
    function automatic logic settled_act(input logic [SYNC_STAGES-1:0] chain, input logic held);
        logic act;
        act = held;
        if (chain[SYNC_STAGES-1] == chain[SYNC_STAGES-2]) begin
            act = ~chain[SYNC_STAGES-1];
        end
        return act;
    endfunction : settled_act

    // Next-state logic
    always_comb begin
        d = q;
        // Pulses default low
        d.handler_start = 1'h0;
        d.resume_exec = 1'h0;
        // Three-stage sampling; act when last two agree
        d.mgmt_sync = shift_in(q.mgmt_sync, mgmt_interrupt_req_n);
        d.halt_sync = shift_in(q.halt_sync, halt_clock_req_n);
        d.mgmt_act = settled_act(q.mgmt_sync, q.mgmt_act);
        d.halt_act = settled_act(q.halt_sync, q.halt_act);
        // Bus side, interrupt unit and snoop run outside reset
        d.bus_clk_en = 1'h1;
        d.irq_unit_clk_en = 1'h1;
        d.snoop_en = 1'h1;
        // Management request seen at reset release tri-states outputs
        d.in_reset = 1'h0;
        if (q.in_reset && q.mgmt_act) begin
            d.outputs_tristate = 1'h1;
        end
        case (q.state)

            // Idle: management request wins over halt, except in the first cycle after reset
            scsb_pkg::SCSB_RUN: begin
                if (q.mgmt_act && !q.in_reset) begin
                    d.state = scsb_pkg::SCSB_SAVE;
                    d.save_state_req = 1'h1;
                end else if (q.halt_act) begin
                    d.state = scsb_pkg::SCSB_GRANT_ACK;
                    d.grant_ack_req = 1'h1;
                end
            end

            // Wait for the core to finish saving state
            scsb_pkg::SCSB_SAVE: begin
                if (state_saved) begin
                    d.save_state_req = 1'h0;
                    d.management_mode = 1'h1;
                    d.mgmt_ack_req = 1'h1;
                    d.state = scsb_pkg::SCSB_MGMT_ACK;
                end
            end

            // Acknowledge transaction on the bus, then handler
            scsb_pkg::SCSB_MGMT_ACK: begin
                if (bus_ack_done) begin
                    d.mgmt_ack_req = 1'h0;
                    d.handler_start = 1'h1;
                    d.state = scsb_pkg::SCSB_MGMT_RUN;
                end
            end

            // Handler runs until it exits
            scsb_pkg::SCSB_MGMT_RUN: begin
                if (handler_exit) begin
                    d.management_mode = 1'h0;
                    d.state = scsb_pkg::SCSB_RUN;
                end
            end

            // Grant acknowledge on the bus, then gate core
            scsb_pkg::SCSB_GRANT_ACK: begin
                if (bus_ack_done) begin
                    d.grant_ack_req = 1'h0;
                    d.core_clk_en = 1'h0;
                    d.state = scsb_pkg::SCSB_GRANT;
                end
            end

            // Core gated until the settled request is withdrawn
            scsb_pkg::SCSB_GRANT: begin
                if (!q.halt_act) begin
                    d.core_clk_en = 1'h1;
                    d.state = scsb_pkg::SCSB_RESUME;
                end
            end

            // One-cycle resume pulse with clocks back
            scsb_pkg::SCSB_RESUME: begin
                d.resume_exec = 1'h1;
                d.state = scsb_pkg::SCSB_RUN;
            end

            // Unused codes return to idle
            default: begin
                d.state = scsb_pkg::SCSB_RUN;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            // Synchronisers keep sampling, so a request held through reset is seen at release
            q.mgmt_sync <= d.mgmt_sync;
            q.halt_sync <= d.halt_sync;
            q.mgmt_act <= d.mgmt_act;
            q.halt_act <= d.halt_act;
            // Controller and its outputs to rest
            q.in_reset <= scsb_pkg::RST_HIGH;
            q.state <= scsb_pkg::SCSB_RUN;
            q.save_state_req <= scsb_pkg::RST_LOW;
            q.mgmt_ack_req <= scsb_pkg::RST_LOW;
            q.grant_ack_req <= scsb_pkg::RST_LOW;
            q.management_mode <= scsb_pkg::RST_LOW;
            q.handler_start <= scsb_pkg::RST_LOW;
            q.core_clk_en <= scsb_pkg::RST_HIGH;
            q.resume_exec <= scsb_pkg::RST_LOW;
            q.outputs_tristate <= scsb_pkg::RST_LOW;
            // Bus side, interrupt unit and snoop held off
            q.bus_clk_en <= scsb_pkg::RST_LOW;
            q.irq_unit_clk_en <= scsb_pkg::RST_LOW;
            q.snoop_en <= scsb_pkg::RST_LOW;
        end else begin
            q <= d;
        end
    end

    // Outputs from flops; bus, interrupt unit, snoop held off only in reset
    assign save_state_req = q.save_state_req;
    assign mgmt_ack_req = q.mgmt_ack_req;
    assign grant_ack_req = q.grant_ack_req;
    assign management_mode = q.management_mode;
    assign handler_start = q.handler_start;
    assign core_clk_en = q.core_clk_en;
    // Units that keep their clock during grant
    assign system_bus_clk_en = q.bus_clk_en;
    assign local_interrupt_controller_clk_en = q.irq_unit_clk_en;
    assign snoop_en = q.snoop_en;
    assign resume_exec = q.resume_exec;
    assign outputs_tristate = q.outputs_tristate;
endmodule : scsb_sideband

// >>> scsb_partner.sv
// Core and bus partner answering the controller handshakes
module scsb_partner (
    // Clock and requests from the controller
    input wire logic ref_clk, save_state_req, mgmt_ack_req, grant_ack_req, management_mode,
    // Handshake answers
    output logic state_saved = 1'h0, bus_ack_done = 1'h0, handler_exit = 1'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Random-latency one-cycle answers, kept in handshake order
    always @(negedge ref_clk) begin
        state_saved <= save_state_req && !state_saved && $urandom % 3 == 0;
        bus_ack_done <= (mgmt_ack_req || grant_ack_req) && !bus_ack_done && $urandom % 3 == 0;
        handler_exit <= management_mode && !mgmt_ack_req && !handler_exit && $urandom % 4 == 0;
    end
endmodule : scsb_partner

// >>> scsb_sideband_checker.sv
// Checker for the sideband controller ports
module scsb_sideband_checker (
    // Watched ports
    input wire logic ref_clk, rstn, halt_clock_req_n, state_saved, bus_ack_done, save_state_req,
    input wire logic mgmt_ack_req, grant_ack_req, management_mode, handler_start,
    input wire logic core_clk_en, system_bus_clk_en, snoop_en, resume_exec,
    input wire logic local_interrupt_controller_clk_en, outputs_tristate
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Resume pulse of one cycle
    sequence resume_pulse;
        resume_exec ##1 !resume_exec;
    endsequence
    a_save_first: assert property ($rose(management_mode) |-> $past(state_saved) && $past(save_state_req))
        else $error("mode entered before save");
    a_save_holds: assert property (save_state_req && !state_saved |=> save_state_req)
        else $error("save request dropped");
    a_ack_on_entry: assert property ($rose(management_mode) |-> mgmt_ack_req)
        else $error("no acknowledge on entry");
    a_handler_after_ack: assert property ($rose(handler_start) |-> $past(bus_ack_done) ##1 !handler_start)
        else $error("handler start out of order");
    a_grant_sync: assert property ($rose(grant_ack_req) |-> !$past(halt_clock_req_n, 3) && core_clk_en)
        else $error("grant without settled request");
    a_gate_after_ack: assert property ($fell(core_clk_en) |-> $past(grant_ack_req) && $past(bus_ack_done))
        else $error("core clock gated early");
    a_bus_kept: assert property (!core_clk_en |-> system_bus_clk_en && local_interrupt_controller_clk_en && snoop_en)
        else $error("bus unit stopped in grant");
    a_resume_step: assert property ($rose(core_clk_en) |=> resume_pulse)
        else $error("no resume pulse");
    a_tristate_keep: assert property (outputs_tristate |=> outputs_tristate)
        else $error("tristate released without reset");
endmodule : scsb_sideband_checker
bind scsb_sideband scsb_sideband_checker chk_u (.*);

// >>> scsb_sideband_bench.sv
// Self-checking bench for the sideband controller
module scsb_sideband_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'h0, rstn = 1'h0, mgmt_interrupt_req_n = 1'h1, halt_clock_req_n = 1'h1;
    logic state_saved, bus_ack_done, handler_exit, save_state_req, mgmt_ack_req, grant_ack_req;
    logic management_mode, handler_start, core_clk_en, system_bus_clk_en, snoop_en, resume_exec;
    logic local_interrupt_controller_clk_en, outputs_tristate;
    logic [1:0] notes[$];
    int n_mismatch = 0, checks_done = 0, cycles = 0;
    scsb_sideband dut_u (.*);
    scsb_partner part_u (.*);
    // Counted compare
    task automatic check(input logic [1:0] got, input logic [1:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Counts and verdict
    task automatic report_and_stop();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    // Timeout and pulse monitor against oldest note
    always @(negedge ref_clk) begin
        cycles++;
        if ((handler_start | resume_exec) === 1'h1) begin
            if (notes.size() == 0)
                check(2'h3, 2'h0);
            else
                check({handler_start, resume_exec}, notes.pop_front());
        end
        if (cycles == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    // Random mix of management and halt sequences
    initial begin
        void'($urandom(32'hF21D));
        repeat (6) @(negedge ref_clk);
        rstn = 1'h1;
        @(negedge ref_clk);
        check({1'h0, outputs_tristate}, 2'h0);
        check({system_bus_clk_en, core_clk_en}, 2'h3);
        repeat (40) begin
            if ($urandom % 2) begin
                mgmt_interrupt_req_n = 1'h0;
                notes.push_back(2'h2);
                repeat (4) @(negedge ref_clk);
                mgmt_interrupt_req_n = 1'h1;
                wait (management_mode === 1'h1);
                wait (management_mode === 1'h0);
            end else begin
                halt_clock_req_n = 1'h0;
                notes.push_back(2'h1);
                wait (core_clk_en === 1'h0);
                repeat ($urandom % 8 + 1) @(negedge ref_clk);
                check({local_interrupt_controller_clk_en, snoop_en}, 2'h3);
                check({core_clk_en, system_bus_clk_en}, 2'h1);
                halt_clock_req_n = 1'h1;
                wait (resume_exec === 1'h1);
            end
            repeat ($urandom % 4 + 1) @(negedge ref_clk);
        end
        check({1'h0, outputs_tristate}, 2'h0);
        // Request held through a second reset tri-states the outputs
        mgmt_interrupt_req_n = 1'h0;
        rstn = 1'h0;
        repeat (6) @(negedge ref_clk);
        rstn = 1'h1;
        @(negedge ref_clk);
        check({1'h0, outputs_tristate}, 2'h1);
        notes.push_back(2'h2);
        mgmt_interrupt_req_n = 1'h1;
        wait (management_mode === 1'h1);
        wait (management_mode === 1'h0);
        @(negedge ref_clk);
        check({1'h0, outputs_tristate}, 2'h1);
        report_and_stop();
    end
endmodule : scsb_sideband_bench
